// ---- verilog/adc_readout_params.svh ----
// Constants shared by both ends of the converter result readout link.
// Assumes the link clock period below matches the clock on the interface.
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH

// ==========================================================================
// Word format
`define WORD_BITS        12
`define IDX_BITS         4

// ==========================================================================
// Clock rates
`define LINK_PERIOD_NS   64
`define CLK_PERIOD_NS    20

// ==========================================================================
// Device timing, counted in link clock cycles
`define CONVERT_NS       12000
`define CONVERT_CYC      (`CONVERT_NS / `LINK_PERIOD_NS)
`define INT_LEAD_NS      2000
`define INT_LEAD_CYC     (`INT_LEAD_NS / `LINK_PERIOD_NS)
`define INT_HALF_NS      355
`define INT_HALF_CYC     (`INT_HALF_NS / `LINK_PERIOD_NS)
`define INT_DATA_PH      2

// ==========================================================================
// Host timing, counted in system clock cycles
`define START_GAP_NS     25000
`define START_GAP_CYC    ((`START_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_PULSE_NS   200
`define START_PULSE_CYC  ((`START_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOST_SCLK_DIV    40

// ==========================================================================
// Reset values
`define BUSY_N_RST       1'b1
`define PIN_HIGH_RST     2'b11

`endif

// ---- verilog/adc_readout_pkg.sv ----
// Types shared by both ends of the converter result readout link.
// Assumes the constants header is on the include path.
`include "adc_readout_params.svh"

package adc_readout_pkg;

  // ========================================================================
  // State encodings
  typedef enum logic [0:0] {
    DEV_IDLE = 1'b0,
    DEV_BUSY = 1'b1
  } dev_state_type;

  typedef enum logic [2:0] {
    HOST_IDLE  = 3'b000,
    HOST_START = 3'b001,
    HOST_WBUSY = 3'b010,
    HOST_WDONE = 3'b011,
    HOST_READ  = 3'b100
  } host_state_type;

  // ========================================================================
  // Register sets
  typedef struct packed {
    logic [1:0]             cv_s;
    logic [1:0]             cs_s;
    logic [1:0]             sck_s;
    logic [1:0]             ext_s;
    logic                   cv_prev;
    logic                   sck_prev;
    dev_state_type          st;
    logic [7:0]             tmr;
    logic [`WORD_BITS-1:0]  held;
    logic [`WORD_BITS-1:0]  shreg;
    logic [`IDX_BITS-1:0]   idx;
    logic [3:0]             ph;
    logic                   tx;
    logic                   sclk;
    logic                   data;
    logic                   busy_n;
    logic                   outs_en;
    logic                   sclk_en;
  } dev_reg_type;

  typedef struct packed {
    logic [1:0]             busy_s;
    logic [1:0]             data_s;
    logic [1:0]             sck_s;
    logic                   busy_prev;
    logic                   sck_prev;
    host_state_type         st;
    logic [10:0]            gap;
    logic [7:0]             cnt;
    logic [`IDX_BITS-1:0]   nbits;
    logic [`WORD_BITS-1:0]  word;
    logic [`WORD_BITS-1:0]  result;
    logic                   valid;
    logic                   ext;
    logic                   cv_n;
    logic                   cs_n;
    logic                   sclk;
  } host_reg_type;

endpackage

// ---- verilog/adc_link_if.sv ----
// Pins between the converter readout port and its host.
// Assumes the bench drives link_clk; idle levels model weak pulls.
`timescale 1ns/10ps

interface adc_link_if (
  input logic link_clk
);
  logic convert_start_n;
  logic cs_n;
  logic clock_source_select;
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic host_sclk_o;
  logic host_sclk_oe;
  logic shift_clock;
  logic dev_data_o;
  logic dev_data_oe;
  logic data;
  logic dev_busy_n_o;
  logic dev_busy_n_oe;
  logic busy_n;

  // ========================================================================
  // Wire resolution from the output enables.
  assign shift_clock = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe ? host_sclk_o : 1'b0);
  assign data        = dev_data_oe ? dev_data_o : 1'b0;
  assign busy_n      = dev_busy_n_oe ? dev_busy_n_o : 1'b1;

  modport device (
    input  link_clk,
    input  convert_start_n,
    input  cs_n,
    input  clock_source_select,
    input  shift_clock,
    output dev_sclk_o,
    output dev_sclk_oe,
    output dev_data_o,
    output dev_data_oe,
    output dev_busy_n_o,
    output dev_busy_n_oe
  );

  modport host (
    input  shift_clock,
    input  data,
    input  busy_n,
    output convert_start_n,
    output cs_n,
    output clock_source_select,
    output host_sclk_o,
    output host_sclk_oe
  );
endinterface

// ---- verilog/adc_readout_dev.sv ----
// Converter end of the serial result readout: conversion timing, result
// shift register, internal shift clock generation and external shifting.
// Assumes it runs wholly on the link clock; all pins are synchronised.
//
// Summary of operation
// - Internal mode: send result n during n+1
// - Idle internal link: data and clock low
// - Twelve bit twos complement word, MSB first
// - Internal mode: bit stable across both edges
// - Busy low across whole internal transmission
// - External mode: read after, during, or both
// - External mode: first host rising edge starts
// - External mode: bit valid at falling edge
// - Rising-edge host needs one extra clock
// - Clock high at busy rise while selected discards result
// - Shift register loads only at conversion end
// - Host clocks after conversion, static before next
// - Reading during conversion wants 2MHz or faster
// - High select disables outputs, gates host clock
// - Select release disables outputs at any time
// - Conversion starts regardless of select
// - Deselected internal transfer runs, result lost
// - Clock pin driven only in internal mode
// - Slow host may split read across conversions
// - Start ignored while conversion runs
// - Starts no closer than 25 microseconds
`timescale 1ns/10ps
`include "adc_readout_params.svh"

module adc_readout_dev
  import adc_readout_pkg::*;
(
  // Link pins and link clock
  adc_link_if.device           link,
  // Reset of the link clock domain
  input  logic                 i_rst_n,
  // Converter core side
  input  logic [`WORD_BITS-1:0] i_sample,
  output logic [`WORD_BITS-1:0] o_result
);

  localparam int CONVERT_CYC  = `CONVERT_CYC;
  localparam int INT_LEAD_CYC = `INT_LEAD_CYC;
  localparam int HALF_CYC     = `INT_HALF_CYC;

  dev_reg_type q;
  dev_reg_type d;

  logic        ext;
  logic        sel_n;
  logic        sck;
  logic        cv;

  // ========================================================================
  // Bit selection
  function automatic logic msb_bit(
    input logic [`WORD_BITS-1:0] word,
    input logic [`IDX_BITS-1:0]  idx
  );
    logic [`IDX_BITS-1:0] pos;
    pos = `IDX_BITS'(`WORD_BITS - 1) - idx;
    return word[pos];
  endfunction

  assign ext   = q.ext_s[1];
  assign sel_n = q.cs_s[1];
  assign sck   = q.sck_s[1];
  assign cv    = q.cv_s[1];

  // ========================================================================
  // Next state
  always_comb
  begin
    d          = q;
    d.cv_s     = {q.cv_s[0], link.convert_start_n};
    d.cs_s     = {q.cs_s[0], link.cs_n};
    d.sck_s    = {q.sck_s[0], link.shift_clock};
    d.ext_s    = {q.ext_s[0], link.clock_source_select};
    d.cv_prev  = cv;
    d.sck_prev = sck;

    // Output enables follow the select at any moment, whatever is running.
    d.outs_en  = ~sel_n;
    d.sclk_en  = ~sel_n & ~ext;

    case (q.st)
      DEV_IDLE:
      begin
        // A falling start edge is honoured whether or not selected.
        if (q.cv_prev && !cv)
        begin
          d.st     = DEV_BUSY;
          d.tmr    = 8'h00;
          d.held   = i_sample;
          d.busy_n = 1'b0;
          d.tx     = 1'b0;
          d.ph     = 4'h0;
          if (!ext)
          begin
            d.idx  = '0;
          end
        end
      end

      DEV_BUSY:
      begin
        d.tmr = q.tmr + 8'h01;

        // Internal clock mode: the stored word goes out during this
        // conversion, after a fixed lead from the start edge.
        if (!ext && (q.tmr == 8'(INT_LEAD_CYC - 1)))
        begin
          d.tx = 1'b1;
          d.ph = 4'h0;
        end

        if (q.tx)
        begin
          d.ph = q.ph + 4'h1;
          // Data changes inside the low phase, away from both edges.
          if (q.ph == 4'(`INT_DATA_PH))
          begin
            if (q.idx == `IDX_BITS'(`WORD_BITS))
            begin
              d.data = 1'b0;
              d.tx   = 1'b0;
            end
            else
            begin
              d.data = msb_bit(q.shreg, q.idx);
            end
          end
          if ((q.ph == 4'(HALF_CYC - 1)) && (q.idx < `IDX_BITS'(`WORD_BITS)))
          begin
            d.sclk = 1'b1;
          end
          if (q.ph == 4'(2 * HALF_CYC - 1))
          begin
            d.sclk = 1'b0;
            d.ph   = 4'h0;
            if (q.idx < `IDX_BITS'(`WORD_BITS))
            begin
              d.idx = q.idx + `IDX_BITS'(1);
            end
          end
        end

        // End of conversion: busy rises and the word may be loaded.
        if (q.tmr == 8'(CONVERT_CYC - 1))
        begin
          d.st     = DEV_IDLE;
          d.busy_n = 1'b1;
          d.tx     = 1'b0;
          if (!ext)
          begin
            d.sclk = 1'b0;
            d.data = 1'b0;
          end
          // A host clock left high while selected blocks the update and
          // the new result is dropped; the old word stays readable.
          if (!ext || sel_n || !sck)
          begin
            d.shreg = q.held;
            d.idx   = '0;
          end
        end
      end

      default:
      begin
        d.st = DEV_IDLE;
      end
    endcase

    // External clock mode: each gated rising edge presents the next bit,
    // so it is settled by the following falling edge.  Past the last bit
    // the line reads zero.
    if (ext && !sel_n && sck && !q.sck_prev)
    begin
      if (q.idx < `IDX_BITS'(`WORD_BITS))
      begin
        d.data = msb_bit(q.shreg, q.idx);
        d.idx  = q.idx + `IDX_BITS'(1);
      end
      else
      begin
        d.data = 1'b0;
      end
    end

    if (ext)
    begin
      d.sclk = 1'b0;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge link.link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q          <= '0;
      q.cv_s     <= `PIN_HIGH_RST;
      q.cs_s     <= `PIN_HIGH_RST;
      q.cv_prev  <= 1'b1;
      q.busy_n   <= `BUSY_N_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================================
  // Pin drivers
  assign link.dev_sclk_o    = q.sclk;
  assign link.dev_sclk_oe   = q.sclk_en;
  assign link.dev_data_o    = q.data;
  assign link.dev_data_oe   = q.outs_en;
  assign link.dev_busy_n_o  = q.busy_n;
  assign link.dev_busy_n_oe = q.outs_en;
  assign o_result           = q.shreg;

endmodule

// ---- verilog/adc_readout_host.sv ----
// Host end of the readout link: starts conversions, reads each word in
// either clock mode and hands it to the user side.
// Assumes i_clk is the system clock; link inputs are synchronised here.
`timescale 1ns/10ps
`include "adc_readout_params.svh"

module adc_readout_host
  import adc_readout_pkg::*;
#(
  parameter int SCLK_DIV = `HOST_SCLK_DIV
)
(
  // System clock and reset
  input  logic                  i_clk,
  input  logic                  i_rst_n,
  // User request side
  input  logic                  i_start,
  input  logic                  i_ext_mode,
  output logic                  o_ready,
  // User result side
  output logic [`WORD_BITS-1:0] o_result,
  output logic                  o_valid,
  // Link pins
  adc_link_if.host              link
);

  host_reg_type q;
  host_reg_type d;

  logic         busy_n;
  logic         sdata;
  logic         sck;

  assign busy_n = q.busy_s[1];
  assign sdata  = q.data_s[1];
  assign sck    = q.sck_s[1];

  // ========================================================================
  // Next state
  always_comb
  begin
    d           = q;
    d.busy_s    = {q.busy_s[0], link.busy_n};
    d.data_s    = {q.data_s[0], link.data};
    d.sck_s     = {q.sck_s[0], link.shift_clock};
    d.busy_prev = busy_n;
    d.sck_prev  = sck;
    d.valid     = 1'b0;
    if (q.gap != 11'h000)
    begin
      d.gap = q.gap - 11'h001;
    end

    case (q.st)
      HOST_IDLE:
      begin
        d.sclk = 1'b0;
        d.cs_n = 1'b1;
        if (i_start && (q.gap == 11'h000))
        begin
          d.st    = HOST_START;
          d.gap   = 11'(`START_GAP_CYC - 1);
          d.cnt   = 8'h00;
          d.cv_n  = 1'b0;
          d.cs_n  = 1'b0;
          d.ext   = i_ext_mode;
          d.nbits = '0;
        end
      end

      HOST_START:
      begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(`START_PULSE_CYC - 1))
        begin
          d.cv_n = 1'b1;
          d.st   = HOST_WBUSY;
        end
      end

      HOST_WBUSY:
      begin
        if (!busy_n)
        begin
          d.st = HOST_WDONE;
        end
      end

      HOST_WDONE:
      begin
        // Internal mode: take each bit at the device clock's falling edge.
        if (!q.ext && q.sck_prev && !sck)
        begin
          d.word  = {q.word[`WORD_BITS-2:0], sdata};
          d.nbits = q.nbits + `IDX_BITS'(1);
        end
        // External clock is held low here, so the new word will load.
        if (busy_n && !q.busy_prev)
        begin
          if (q.ext)
          begin
            d.st    = HOST_READ;
            d.cnt   = 8'h00;
            d.nbits = '0;
          end
          else
          begin
            d.result = q.word;
            d.valid  = 1'b1;
            d.st     = HOST_IDLE;
          end
        end
      end

      HOST_READ:
      begin
        // Whole word is read before the next start, so the clock is
        // static during the next conversion; sampling on falling edges
        // needs no extra period.
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(SCLK_DIV / 2 - 1))
        begin
          d.sclk = 1'b1;
        end
        if (q.cnt == 8'(SCLK_DIV - 1))
        begin
          d.sclk  = 1'b0;
          d.cnt   = 8'h00;
          d.word  = {q.word[`WORD_BITS-2:0], sdata};
          d.nbits = q.nbits + `IDX_BITS'(1);
          if (q.nbits == `IDX_BITS'(`WORD_BITS - 1))
          begin
            d.result = {q.word[`WORD_BITS-2:0], sdata};
            d.valid  = 1'b1;
            d.cs_n   = 1'b1;
            d.st     = HOST_IDLE;
          end
        end
      end

      default:
      begin
        d.st = HOST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q           <= '0;
      q.busy_s    <= `PIN_HIGH_RST;
      q.busy_prev <= 1'b1;
      q.cv_n      <= 1'b1;
      q.cs_n      <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  assign o_ready                  = (q.st == HOST_IDLE) && (q.gap == 11'h000);
  assign o_result                 = q.result;
  assign o_valid                  = q.valid;
  assign link.convert_start_n     = q.cv_n;
  assign link.cs_n                = q.cs_n;
  assign link.clock_source_select = q.ext;
  assign link.host_sclk_o         = q.sclk;
  assign link.host_sclk_oe        = q.ext;

endmodule

// ---- tb/adc_readout_properties.sv ----
// Concurrent checks on the readout link pins, clocked by the link clock.
// Assumes it is instantiated beside the link interface with the device reset.
`timescale 1ns/10ps

module adc_readout_properties (
  // Link clock and device reset
  input logic link_clk,
  input logic i_rst_n,
  // Resolved link pins
  input logic convert_start_n,
  input logic cs_n,
  input logic clock_source_select,
  input logic shift_clock,
  input logic data,
  input logic busy_n,
  // Device output enables
  input logic dev_sclk_oe,
  input logic dev_data_oe,
  input logic dev_busy_n_oe
);
  logic [8:0] busy_cnt_q;
  logic [4:0] pulse_cnt_q;
  logic       sclk_q;

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ==========================================================================
  // Helper counters
  // Counts are cleared while busy is high so each frame is judged on its own.
  always_ff @(posedge link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_cnt_q  <= 9'h000;
      pulse_cnt_q <= 5'h00;
      sclk_q      <= 1'b0;
    end
    else
    begin
      busy_cnt_q  <= busy_n ? 9'h000 : busy_cnt_q + 9'h001;
      pulse_cnt_q <= busy_n ? 5'h00 : pulse_cnt_q + {4'h0, shift_clock & ~sclk_q};
      sclk_q      <= shift_clock;
    end
  end

  // ==========================================================================
  // Assertions
  idle_data_a: assert property ($rose(busy_n) && !clock_source_select |-> !data)
    else $error("serial data not low after internal frame");
  idle_clock_a: assert property (busy_n && !clock_source_select |-> !shift_clock)
    else $error("shift clock active outside a conversion");
  busy_length_a: assert property ($rose(busy_n) |-> busy_cnt_q inside {[186:187]})
    else $error("busy low time wrong");
  busy_start_a: assert property ($fell(convert_start_n) && busy_n |-> ##[1:8] !busy_n)
    else $error("conversion start not answered by busy");
  pulse_count_a: assert property ($rose(busy_n) && !clock_source_select |-> pulse_cnt_q == 12)
    else $error("internal clock pulse count not twelve");
  bit_stable_a: assert property ($rose(shift_clock) && !clock_source_select |-> $stable(data) [*6])
    else $error("data moved while internal clock pulse ran");
  busy_frame_a: assert property ($rose(shift_clock) && !clock_source_select |-> !busy_n [*6])
    else $error("busy high during internal transmission");
  ext_clock_a: assert property (clock_source_select [*4] |-> !dev_sclk_oe)
    else $error("device drives clock pin in external mode");
  cs_disable_a: assert property (cs_n [*4] |-> !dev_data_oe && !dev_busy_n_oe && !dev_sclk_oe)
    else $error("outputs enabled while deselected");
endmodule

// ---- tb/test_adc_serial_result_readout.sv ----
// Self-checking bench joining both readout ends over the link interface.
// Assumes the design files and the properties checker are compiled first.
`timescale 1ns/10ps
`include "adc_readout_params.svh"

module test_adc_serial_result_readout;
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n;
  logic        dev_rst_n;
  logic        start;
  logic        ext_mode;
  logic        h_ready;
  logic        h_valid;
  logic [11:0] sample;
  logic [11:0] h_result;
  logic [11:0] d_result;
  logic [11:0] wword;
  logic [11:0] shm;
  logic [11:0] exp_q[$];
  logic [11:0] wq[$];
  logic [11:0] bnd[4] = '{12'h7FF, 12'h800, 12'hFFF, 12'h000};
  logic [31:0] seed = 32'h0000_0016;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_valid = 0;
  int          wbits = 0;

  always #10 clk = ~clk;
  always #32 link_clk = ~link_clk;

  // ==========================================================================
  // Design and checker
  adc_link_if link (.link_clk(link_clk));

  adc_readout_dev i_adc_readout_dev (
    .link     (link),
    .i_rst_n  (dev_rst_n),
    .i_sample (sample),
    .o_result (d_result)
  );

  adc_readout_host #(.SCLK_DIV(40)) i_adc_readout_host (
    .i_clk      (clk),
    .i_rst_n    (rst_n),
    .i_start    (start),
    .i_ext_mode (ext_mode),
    .o_ready    (h_ready),
    .o_result   (h_result),
    .o_valid    (h_valid),
    .link       (link)
  );

  adc_readout_properties i_adc_readout_properties (
    .link_clk            (link_clk),
    .i_rst_n             (dev_rst_n),
    .convert_start_n     (link.convert_start_n),
    .cs_n                (link.cs_n),
    .clock_source_select (link.clock_source_select),
    .shift_clock         (link.shift_clock),
    .data                (link.data),
    .busy_n              (link.busy_n),
    .dev_sclk_oe         (link.dev_sclk_oe),
    .dev_data_oe         (link.dev_data_oe),
    .dev_busy_n_oe       (link.dev_busy_n_oe)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xorshift(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk_word(string what, logic [11:0] exp, logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(string what, int exp, int got);
    comparisons++;
    if (got != exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timeout(string what);
    n_errors++;
    $display("[FAIL] %s expected done seen timeout", what);
    end_sim;
  endtask

  // The model shift register tracks what the device should hold after each load.
  task automatic convert(logic ext, logic [11:0] val);
    int k;
    k = 0;
    @(negedge clk);
    while (h_ready !== 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 3000)
      timeout("ready wait");
    sample = val;
    ext_mode = ext;
    start = 1'b1;
    if (ext)
    begin
      shm = val;
      exp_q.push_back(val);
    end
    else
    begin
      exp_q.push_back(shm);
      wq.push_back(shm);
      shm = val;
    end
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic wait_valid(int n);
    int k;
    k = 0;
    while (n_valid < n && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 4000)
      timeout("result wait");
  endtask

  // ==========================================================================
  // Result monitors
  // Sampled half a cycle after launch so the registered pulse has settled.
  always @(negedge clk)
  begin
    if (h_valid === 1'b1)
    begin
      if (exp_q.size() > 0)
        chk_word("host result", exp_q.pop_front(), h_result);
      else
        chk_word("host result", 12'h000, 12'hXXX);
      n_valid++;
    end
  end

  // Only internal frames are rebuilt from the wire; the device owns that clock.
  always @(posedge link.shift_clock)
  begin
    if (link.clock_source_select === 1'b0)
    begin
      wword = {wword[10:0], link.data};
      wbits++;
    end
  end

  // The shift register loads on the same link edge that raises busy.
  always @(posedge link.busy_n)
  begin
    #1;
    if (dev_rst_n === 1'b1)
      chk_word("device word", shm, d_result);
    if (wbits != 0)
    begin
      chk_cnt("serial bits", 12, wbits);
      if (wq.size() > 0)
        chk_word("serial word", wq.pop_front(), wword);
      wbits = 0;
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    dev_rst_n = 1'b0;
    start = 1'b0;
    ext_mode = 1'b0;
    sample = 12'h000;
    shm = 12'h000;
    wword = 12'h000;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge link_clk);
    dev_rst_n = 1'b1;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      seed = xorshift(seed);
      convert(i[1], (i < 4) ? bnd[i] : seed[11:0]);
      wait_valid(i + 1);
      $display("test %0d done, external mode %0d", i, i[1]);
    end
    repeat (20) @(negedge clk);
    chk_cnt("pending results", 0, exp_q.size() + wq.size());
    end_sim;
  end
endmodule
